/* hdl/uifm_map.svh */
// Purpose: offsets, fields, reset values and counts of the channel block
// Assumes: byte addresses on a 32-bit AXI4-Lite bus
// Notes:   one aligned word per register
// How it works
// R1: Highest enabled pending source gives the code in ident bits 3..0.
// R2: FIFO mode: four idle character times with data raises timeout.
// R3: Ident read reporting transmit-empty, or holding write, clears it.
// R4: Ident bits 7:6 read ones in FIFO mode, else zeros.
// R5: Disabled sources neither show in ident nor drive the interrupt.
// R6: Enable bits: 0 receive/timeout, 1 transmit, 2 line, 3 modem.
// R7: Enable register bits 7:4 always read zero.
// R8: Scratch register holds any written byte, controls nothing.
// R9: FIFO control is write-only at the ident address.
// R10: FIFO control bit 0 enables both FIFOs; switching keeps data.
// R11: Other FIFO control bits are ignored when bit 0 is written zero.
// R12: FIFO control bit 1 flushes receive counters, then self-clears.
// R13: FIFO control bit 2 flushes transmit counters, then self-clears.
// R14: FIFO control bit 3 selects DMA request mode 1 in FIFO mode.
// R15: FIFO control bits 7:6 pick trigger 1, 4, 8 or 14 bytes.
// R16: Modem control bit 0 drives terminal-ready low when set.
// R17: Modem control bit 1 drives request-to-send low when set.
// R18: Modem control bit 2 drives internal auxiliary output one.
// R19: Modem control bit 3 drives auxiliary two and gates interrupt pin.
// R20: Loopback: serial out high, inputs cut, modem outputs high; auxiliary outputs one and two still follow bits 2 and 3.
// R21: Loopback modem lines come from modem control bits 3..0.
// R22: Modem control bits 7:5 always read zero.
// R23: Ident bit 0 low when pending; read freezes reported source.
// R24: Enable, FIFO control and modem control reset to zero.
`ifndef UIFM_MAP_SVH
`define UIFM_MAP_SVH
`define UIFM_OFS_IER     8'h04
`define UIFM_OFS_IIR     8'h08
`define UIFM_OFS_MCR     8'h10
`define UIFM_OFS_SCR     8'h1C
`define UIFM_IER_RDA     0
`define UIFM_IER_THR     1
`define UIFM_IER_LSR     2
`define UIFM_IER_MSR     3
`define UIFM_FCR_EN      0
`define UIFM_FCR_RXFL    1
`define UIFM_FCR_TXFL    2
`define UIFM_FCR_DMA     3
`define UIFM_MCR_DTR     0
`define UIFM_MCR_RTS     1
`define UIFM_MCR_AUX1    2
`define UIFM_MCR_AUX2    3
`define UIFM_MCR_LOOP    4
`define UIFM_RST_IER     4'h0
`define UIFM_RST_MCR     5'h00
`define UIFM_TMO_CHARS   3'd4
`define UIFM_TRIG_1      5'd1
`define UIFM_TRIG_4      5'd4
`define UIFM_TRIG_8      5'd8
`define UIFM_TRIG_14     5'd14
`define UIFM_RESP_OKAY   2'b00
`define UIFM_RESP_SLVERR 2'b10
`endif

/* hdl/uifm_pkg.sv */
// Purpose: shared types of the channel control block
// Assumes: nothing beyond SystemVerilog packages
// Notes:   source order is the priority order
package uifm_pkg;
   typedef enum logic [2:0] {
      SRC_NONE, SRC_LSR, SRC_RDA, SRC_TMO, SRC_THR, SRC_MSR
   } uifm_src_t;
endpackage

/* hdl/uifm_ctrl.sv */
// Purpose: interrupt, FIFO control, scratch and modem control of a channel
// Assumes: status inputs synchronous to aclk; char_tick one pulse per char
// Notes:   registers on AXI4-Lite, unmapped reads and writes get SLVERR
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "uifm_map.svh"
module uifm_ctrl #(
   parameter int ADDR_W  = 8,
   parameter int CNT_W   = 5
) (
   // Clock and reset
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [ADDR_W-1:0]  s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   // Status from the rest of the channel
   input  wire logic               line_status_pend,
   input  wire logic               modem_status_pend,
   input  wire logic               thr_empty,
   input  wire logic               thr_write,
   input  wire logic               tx_fifo_full,
   input  wire logic [CNT_W-1:0]   rx_fifo_count,
   input  wire logic               rx_push,
   input  wire logic               rx_pop,
   input  wire logic               char_tick,
   // Serial and modem lines
   input  wire logic               serial_in_pin,
   input  wire logic               tx_shift_out,
   input  wire logic               cts_n,
   input  wire logic               dsr_n,
   input  wire logic               ri_n,
   input  wire logic               rlsd_n,
   output logic                    serial_out_pin,
   output logic                    rx_shift_in,
   output logic [3:0]              modem_lines,
   output logic                    dtr_n,
   output logic                    rts_n,
   output logic                    aux_output_one,
   output logic                    aux_output_two,
   // FIFO control and requests
   output logic                    fifo_enable,
   output logic                    receive_flush,
   output logic                    transmit_flush,
   output logic                    receive_dma_request,
   output logic                    transmit_dma_request,
   output logic                    channel_interrupt_pin
);
   import uifm_pkg::*;

   logic [3:0]         ier_reg;
   logic [4:0]         mcr_reg;
   logic [7:0]         scr_reg;
   logic               fen_reg;
   logic               dma_reg;
   logic [1:0]         trig_reg;
   logic [2:0]         tmo_cnt_reg;
   logic               tmo_reg;
   logic               thre_reg;
   logic               thr_empty_q;
   logic               frz_reg;
   uifm_src_t          frz_src_reg;
   logic               aw_got_reg;
   logic               w_got_reg;
   logic [ADDR_W-1:0]  aw_addr_reg;
   logic [31:0]        w_data_reg;
   logic [3:0]         w_strb_reg;
   logic [5:0]         pend;
   logic               rda_level;
   logic [CNT_W-1:0]   trig_bytes;
   uifm_src_t          cur_src;
   uifm_src_t          rep_src;
   logic               wr_do;
   logic               rd_do;
   logic               iir_rd;

   // Index of pend follows the source enum
   function automatic uifm_src_t pick(input logic [5:0] p);
      if (p[SRC_LSR])      return SRC_LSR;
      else if (p[SRC_RDA]) return SRC_RDA;
      else if (p[SRC_TMO]) return SRC_TMO;
      else if (p[SRC_THR]) return SRC_THR;
      else if (p[SRC_MSR]) return SRC_MSR;
      else                 return SRC_NONE;
   endfunction

   function automatic logic [3:0] code(input uifm_src_t s);
      case (s)
         SRC_LSR: code = 4'h6;
         SRC_RDA: code = 4'h4;
         SRC_TMO: code = 4'hC;
         SRC_THR: code = 4'h2;
         SRC_MSR: code = 4'h0;
         default: code = 4'h1;
      endcase
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a == `UIFM_OFS_IER) || (a == `UIFM_OFS_IIR) ||
               (a == `UIFM_OFS_MCR) || (a == `UIFM_OFS_SCR);
   endfunction

   // Trigger depth from bits 7:6
   always_comb begin
      case (trig_reg)
         2'b00:   trig_bytes = `UIFM_TRIG_1; // R15
         2'b01:   trig_bytes = `UIFM_TRIG_4; // R15
         2'b10:   trig_bytes = `UIFM_TRIG_8; // R15
         default: trig_bytes = `UIFM_TRIG_14; // R15
      endcase
   end

   // Character mode reports one byte as data available
   assign rda_level = fen_reg ? (rx_fifo_count >= trig_bytes)
                              : (rx_fifo_count != '0);

   // Enabled sources only
   always_comb begin
      pend = '0;
      pend[SRC_LSR] = ier_reg[`UIFM_IER_LSR] & line_status_pend; // R5 R6
      pend[SRC_RDA] = ier_reg[`UIFM_IER_RDA] & rda_level; // R5 R6
      // Timeout exists only in FIFO mode, even if the flag lingers
      pend[SRC_TMO] = ier_reg[`UIFM_IER_RDA] & tmo_reg & fen_reg; // R2 R6
      pend[SRC_THR] = ier_reg[`UIFM_IER_THR] & thre_reg; // R5 R6
      pend[SRC_MSR] = ier_reg[`UIFM_IER_MSR] & modem_status_pend; // R5 R6
   end

   assign cur_src = pick(pend); // R1
   assign rep_src = frz_reg ? frz_src_reg : cur_src; // R23

   // AXI handshakes
   assign wr_do  = aw_got_reg && w_got_reg && !s_axi_bvalid;
   assign rd_do  = s_axi_arvalid && s_axi_arready;
   assign iir_rd = rd_do && (s_axi_araddr == `UIFM_OFS_IIR);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_reg    <= 1'b0;
         aw_addr_reg   <= '0;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_got_reg && !(s_axi_awvalid && s_axi_awready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg  <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (wr_do) begin
            aw_got_reg  <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_got_reg    <= 1'b0;
         w_data_reg   <= '0;
         w_strb_reg   <= '0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_got_reg && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg  <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (wr_do) begin
            w_got_reg  <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `UIFM_RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(aw_addr_reg) ? `UIFM_RESP_OKAY
                                             : `UIFM_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Register writes; only byte lane 0 carries data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ier_reg        <= `UIFM_RST_IER; // R24
         mcr_reg        <= `UIFM_RST_MCR; // R24
         scr_reg        <= '0;
         fen_reg        <= 1'b0; // R24
         dma_reg        <= 1'b0;
         trig_reg       <= 2'b00;
         receive_flush  <= 1'b0;
         transmit_flush <= 1'b0;
      end else begin
         receive_flush  <= 1'b0; // R12
         transmit_flush <= 1'b0; // R13
         if (wr_do && w_strb_reg[0]) begin
            case (aw_addr_reg)
               `UIFM_OFS_IER: ier_reg <= w_data_reg[3:0]; // R6
               `UIFM_OFS_MCR: mcr_reg <= w_data_reg[4:0];
               `UIFM_OFS_SCR: scr_reg <= w_data_reg[7:0]; // R8
               `UIFM_OFS_IIR: begin // R9
                  // FIFO data is never touched by the mode switch
                  fen_reg <= w_data_reg[`UIFM_FCR_EN]; // R10
                  if (w_data_reg[`UIFM_FCR_EN]) begin // R11
                     receive_flush  <= w_data_reg[`UIFM_FCR_RXFL]; // R12
                     transmit_flush <= w_data_reg[`UIFM_FCR_TXFL]; // R13
                     dma_reg        <= w_data_reg[`UIFM_FCR_DMA]; // R14
                     trig_reg       <= w_data_reg[7:6]; // R15
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // Reads; ident shares its address with the write-only FIFO control
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= `UIFM_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !rd_do;
         if (rd_do) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `UIFM_RESP_OKAY;
            s_axi_rdata  <= '0;
            case (s_axi_araddr)
               `UIFM_OFS_IER: s_axi_rdata[3:0] <= ier_reg; // R7
               `UIFM_OFS_MCR: s_axi_rdata[4:0] <= mcr_reg; // R22
               `UIFM_OFS_SCR: s_axi_rdata[7:0] <= scr_reg; // R8
               `UIFM_OFS_IIR: begin // R9
                  s_axi_rdata[7:6] <= {2{fen_reg}}; // R4
                  s_axi_rdata[3:0] <= code(rep_src); // R1 R23
               end
               default: s_axi_rresp <= `UIFM_RESP_SLVERR;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Freeze holds the reported source until its cause is gone
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frz_reg     <= 1'b0;
         frz_src_reg <= SRC_NONE;
      end else if (frz_reg && !pend[frz_src_reg]) begin
         frz_reg     <= 1'b0; // R23
      end else if (iir_rd && !frz_reg && cur_src != SRC_NONE) begin
         frz_reg     <= 1'b1; // R23
         frz_src_reg <= cur_src;
      end
   end

   // Timeout counts char ticks while data sits idle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tmo_cnt_reg <= '0;
         tmo_reg     <= 1'b0;
      end else if (rx_pop) begin
         tmo_cnt_reg <= '0;
         tmo_reg     <= 1'b0; // R2
      end else if (!fen_reg || rx_push || rx_fifo_count == '0) begin
         tmo_cnt_reg <= '0;
      end else if (char_tick && tmo_cnt_reg != `UIFM_TMO_CHARS) begin
         tmo_cnt_reg <= tmo_cnt_reg + 3'd1;
         if (tmo_cnt_reg == `UIFM_TMO_CHARS - 3'd1) begin
            tmo_reg <= 1'b1; // R2
         end
      end
   end

   // Empty edge sets; a set in the clearing cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         thr_empty_q <= 1'b0;
         thre_reg    <= 1'b0;
      end else begin
         thr_empty_q <= thr_empty;
         if (thr_empty && !thr_empty_q) begin
            thre_reg <= 1'b1;
         end else if (thr_write || (iir_rd && rep_src == SRC_THR)) begin
            thre_reg <= 1'b0; // R3
         end
      end
   end

   // Pins and requests, all registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_out_pin        <= 1'b1;
         rx_shift_in           <= 1'b1;
         modem_lines           <= '0;
         dtr_n                 <= 1'b1;
         rts_n                 <= 1'b1;
         aux_output_one        <= 1'b0;
         aux_output_two        <= 1'b0;
         fifo_enable           <= 1'b0;
         receive_dma_request   <= 1'b0;
         transmit_dma_request  <= 1'b0;
         channel_interrupt_pin <= 1'b0;
      end else begin
         aux_output_one <= mcr_reg[`UIFM_MCR_AUX1]; // R18
         aux_output_two <= mcr_reg[`UIFM_MCR_AUX2]; // R19
         fifo_enable    <= fen_reg; // R10
         if (mcr_reg[`UIFM_MCR_LOOP]) begin
            serial_out_pin <= 1'b1; // R20
            rx_shift_in    <= tx_shift_out; // R20
            dtr_n          <= 1'b1; // R20
            rts_n          <= 1'b1; // R20
            // Order: rlsd, ri, dsr, cts
            modem_lines    <= {mcr_reg[`UIFM_MCR_AUX2],
                               mcr_reg[`UIFM_MCR_AUX1],
                               mcr_reg[`UIFM_MCR_DTR],
                               mcr_reg[`UIFM_MCR_RTS]}; // R21
         end else begin
            serial_out_pin <= tx_shift_out;
            rx_shift_in    <= serial_in_pin;
            dtr_n          <= !mcr_reg[`UIFM_MCR_DTR]; // R16
            rts_n          <= !mcr_reg[`UIFM_MCR_RTS]; // R17
            modem_lines    <= ~{rlsd_n, ri_n, dsr_n, cts_n};
         end
         // Mode 1 needs FIFO mode; it batches transfers
         if (fen_reg && dma_reg) begin // R14
            receive_dma_request  <= rda_level || tmo_reg;
            transmit_dma_request <= !tx_fifo_full;
         end else begin
            receive_dma_request  <= rx_fifo_count != '0;
            transmit_dma_request <= thr_empty;
         end
         channel_interrupt_pin <= (pend != '0) &&
                                  mcr_reg[`UIFM_MCR_AUX2]; // R5 R19
      end
   end

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_iir_read;
      rd_do && s_axi_araddr == `UIFM_OFS_IIR;
   endsequence

   sequence s_fcr_write(bit en);
      wr_do && w_strb_reg[0] && aw_addr_reg == `UIFM_OFS_IIR &&
      w_data_reg[0] == en;
   endsequence

   AST_IDENT_NONE: assert property ( // R23
      s_iir_read ##0 (pend == '0 && !frz_reg) |=>
      s_axi_rdata[3:0] == 4'h1)
      else $error("ident not idle code with nothing pending");
   AST_FIFO_BITS: assert property ( // R4
      s_iir_read |=> s_axi_rdata[7:6] == {2{$past(fen_reg)}} &&
      s_axi_rdata[5:4] == 2'b00)
      else $error("ident bits 7:6 wrong for FIFO mode");
   AST_IER_HI: assert property ( // R7
      rd_do && s_axi_araddr == `UIFM_OFS_IER |=> s_axi_rdata[7:4] == 4'h0)
      else $error("enable high bits not zero");
   AST_MCR_HI: assert property ( // R22
      rd_do && s_axi_araddr == `UIFM_OFS_MCR |=> s_axi_rdata[7:5] == 3'h0)
      else $error("modem control high bits not zero");
   AST_FCR_IGNORE: assert property ( // R11
      s_fcr_write(1'b0) |=> !receive_flush && !transmit_flush &&
      $stable(trig_reg) && $stable(dma_reg))
      else $error("FIFO control bits taken with bit 0 clear");
   AST_FLUSH_PULSE: assert property ( // R12
      receive_flush |=> !receive_flush)
      else $error("receive flush did not self clear");
   AST_TX_FLUSH: assert property ( // R13
      s_fcr_write(1'b1) ##0 w_data_reg[2] |=> transmit_flush ##1
      !transmit_flush)
      else $error("transmit flush not one pulse");
   AST_LOOP: assert property ( // R20
      mcr_reg[`UIFM_MCR_LOOP] [*2] |-> serial_out_pin && dtr_n && rts_n)
      else $error("loopback pins not high");
   AST_DTR: assert property ( // R16
      !mcr_reg[`UIFM_MCR_LOOP] [*2] |-> dtr_n == !$past(mcr_reg[0]))
      else $error("terminal ready not inverse of bit 0");
   AST_THR_CLR: assert property ( // R3
      thr_write && !(thr_empty && !thr_empty_q) |=> !thre_reg)
      else $error("transmit empty not cleared by write");
   AST_TMO_CLR: assert property ( // R2
      rx_pop |=> !tmo_reg && tmo_cnt_reg == 3'd0)
      else $error("timeout not cleared by read");
   AST_IRQ_GATE: assert property ( // R19
      !mcr_reg[`UIFM_MCR_AUX2] |=> !channel_interrupt_pin)
      else $error("interrupt pin active with aux two clear");
endmodule
`default_nettype wire

/* tb/uifm_far_model.sv */
// Purpose: modem, serial and character timer side of one channel
// Assumes: the bench sets the line pattern between checks
// Notes:   char_tick runs free; short period keeps timeout runs brief
`timescale 1ns/1ps
`default_nettype none
module uifm_far_model #(
   parameter int TICK_CYC = 8
) (
   // Clock, reset and pattern {tx, sin, rlsd_n, ri_n, dsr_n, cts_n}
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [5:0] pat,
   // Lines toward the block
   output logic            tx_shift_out,
   output logic            serial_in_pin,
   output logic            rlsd_n,
   output logic            ri_n,
   output logic            dsr_n,
   output logic            cts_n,
   output logic            char_tick
);
   int cnt;
   // Pins follow the pattern; loopback must hide them
   always_ff @(posedge aclk) begin
      {tx_shift_out, serial_in_pin, rlsd_n, ri_n, dsr_n, cts_n} <= pat;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || cnt == TICK_CYC - 1) begin
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
      char_tick <= aresetn && cnt == TICK_CYC - 1;
   end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Purpose: register-level tests of the channel control block
// Assumes: AXI4-Lite master tasks, status inputs driven directly
// Notes:   outputs lag one cycle, so checks wait a few edges
`timescale 1ns/1ps
`default_nettype none
`include "uifm_map.svh"
module testbench;
   import uifm_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, modem_lines;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic line_status_pend, modem_status_pend, thr_empty, thr_write;
   logic tx_fifo_full, rx_push, rx_pop, char_tick, serial_in_pin;
   logic tx_shift_out, cts_n, dsr_n, ri_n, rlsd_n, serial_out_pin;
   logic rx_shift_in, dtr_n, rts_n, aux_output_one, aux_output_two;
   logic fifo_enable, receive_flush, transmit_flush;
   logic receive_dma_request, transmit_dma_request, channel_interrupt_pin;
   logic [4:0] rx_fifo_count;
   logic [5:0] pat;
   logic [31:0] d;
   logic [4:0] trig [4];
   int n_errors, cmp_count, cyc, rxf_n, txf_n;
   uifm_ctrl u_uifm_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_status_pend,
      .modem_status_pend, .thr_empty, .thr_write, .tx_fifo_full,
      .rx_fifo_count, .rx_push, .rx_pop, .char_tick, .serial_in_pin,
      .tx_shift_out, .cts_n, .dsr_n, .ri_n, .rlsd_n, .serial_out_pin,
      .rx_shift_in, .modem_lines, .dtr_n, .rts_n, .aux_output_one,
      .aux_output_two, .fifo_enable, .receive_flush, .transmit_flush,
      .receive_dma_request, .transmit_dma_request, .channel_interrupt_pin);
   uifm_far_model u_uifm_far_model (.aclk, .aresetn, .pat, .tx_shift_out,
      .serial_in_pin, .rlsd_n, .ri_n, .dsr_n, .cts_n, .char_tick);
   initial begin
      aclk = 0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      rxf_n <= rxf_n + (receive_flush === 1'b1);
      txf_n <= txf_n + (transmit_flush === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [39:0] g, input logic [39:0] e);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Both channels offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, v};
      s_axi_wstrb <= 4'h1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         @(posedge aclk);
         if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 0;
         if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
      chk(s_axi_bresp, `UIFM_RESP_OKAY);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do begin
         @(posedge aclk);
         if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      chk({r, d}, {`UIFM_RESP_OKAY, 24'h00_0000, e});
   endtask
   task automatic settle();
      repeat (3) @(posedge aclk);
   endtask
   // Count change with a push, so the idle timer restarts
   task automatic set_cnt(input logic [4:0] c);
      rx_fifo_count <= c;
      rx_push <= 1;
      @(posedge aclk);
      rx_push <= 0;
      settle();
   endtask
   initial begin
      trig = '{`UIFM_TRIG_1, `UIFM_TRIG_4, `UIFM_TRIG_8, `UIFM_TRIG_14};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
      {s_axi_arvalid, s_axi_rready, aresetn, thr_write, rx_push} = 0;
      {line_status_pend, modem_status_pend, thr_empty, tx_fifo_full} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 0;
      {rx_pop, rx_fifo_count, n_errors, cmp_count, cyc} = 0;
      {rxf_n, txf_n} = 0;
      pat = 6'b00_1111;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      rchk(`UIFM_OFS_IER, 8'h00);
      rchk(`UIFM_OFS_MCR, 8'h00);
      rchk(`UIFM_OFS_IIR, 8'h01);
      chk({dtr_n, rts_n, fifo_enable}, 3'b110);
      wr(`UIFM_OFS_SCR, 8'hA5);
      rchk(`UIFM_OFS_SCR, 8'hA5);
      rchk(`UIFM_OFS_IIR, 8'h01);
      wr(`UIFM_OFS_IER, 8'hFF);
      rchk(`UIFM_OFS_IER, 8'h0F);
      wr(`UIFM_OFS_MCR, 8'hFF);
      rchk(`UIFM_OFS_MCR, 8'h1F);
      wr(`UIFM_OFS_MCR, 8'h00);
      rd(8'h20);
      chk({r, d}, {`UIFM_RESP_SLVERR, 32'h0000_0000});
      {line_status_pend, modem_status_pend, thr_empty} <= 3'b111;
      set_cnt(5'd1);
      chk(channel_interrupt_pin, 1'b0);
      wr(`UIFM_OFS_MCR, 8'h08);
      settle();
      chk(channel_interrupt_pin, 1'b1);
      rchk(`UIFM_OFS_IIR, 8'h06);
      line_status_pend <= 0;
      settle();
      rchk(`UIFM_OFS_IIR, 8'h04);
      set_cnt(5'd0);
      rchk(`UIFM_OFS_IIR, 8'h02);
      rchk(`UIFM_OFS_IIR, 8'h00);
      modem_status_pend <= 0;
      settle();
      rchk(`UIFM_OFS_IIR, 8'h01);
      chk(channel_interrupt_pin, 1'b0);
      line_status_pend <= 1;
      wr(`UIFM_OFS_IER, 8'h0B);
      settle();
      rchk(`UIFM_OFS_IIR, 8'h01);
      chk(channel_interrupt_pin, 1'b0);
      wr(`UIFM_OFS_IER, 8'h0F);
      rchk(`UIFM_OFS_IIR, 8'h06);
      line_status_pend <= 0;
      thr_empty <= 0;
      settle();
      thr_empty <= 1;
      settle();
      chk(channel_interrupt_pin, 1'b1);
      thr_write <= 1;
      @(posedge aclk);
      thr_write <= 0;
      settle();
      chk(channel_interrupt_pin, 1'b0);
      wr(`UIFM_OFS_IIR, 8'hC8);
      rchk(`UIFM_OFS_IIR, 8'h01);
      wr(`UIFM_OFS_IIR, 8'h01);
      rchk(`UIFM_OFS_IIR, 8'hC1);
      wr(`UIFM_OFS_IIR, 8'h07);
      settle();
      chk({rxf_n[3:0], txf_n[3:0]}, 8'h11);
      chk({receive_flush, transmit_flush}, 2'b00);
      wr(`UIFM_OFS_IIR, 8'h06);
      settle();
      chk({rxf_n[3:0], txf_n[3:0], fifo_enable}, 9'h022);
      for (int i = 0; i < 4; i++) begin
         wr(`UIFM_OFS_IIR, {i[1:0], 6'b00_1001});
         set_cnt(trig[i] - 5'd1);
         chk(receive_dma_request, 1'b0);
         set_cnt(trig[i]);
         chk(receive_dma_request, 1'b1);
      end
      tx_fifo_full <= 1;
      settle();
      chk(transmit_dma_request, 1'b0);
      wr(`UIFM_OFS_IIR, 8'h01);
      settle();
      chk({transmit_dma_request, receive_dma_request}, 2'b11);
      thr_empty <= 0;
      settle();
      chk(transmit_dma_request, 1'b0);
      wr(`UIFM_OFS_IIR, 8'h41);
      set_cnt(5'd1);
      repeat (12) @(posedge aclk);
      rchk(`UIFM_OFS_IIR, 8'hC1);
      repeat (40) @(posedge aclk);
      rchk(`UIFM_OFS_IIR, 8'hCC);
      rx_pop <= 1;
      @(posedge aclk);
      rx_pop <= 0;
      settle();
      rchk(`UIFM_OFS_IIR, 8'hC1);
      wr(`UIFM_OFS_MCR, 8'h0F);
      pat <= 6'b01_0101;
      settle();
      chk({dtr_n, rts_n, aux_output_one, aux_output_two, serial_out_pin,
         rx_shift_in, modem_lines}, 10'b00_1101_1010);
      wr(`UIFM_OFS_MCR, 8'h15);
      settle();
      chk({dtr_n, rts_n, aux_output_one, aux_output_two, serial_out_pin,
         rx_shift_in, modem_lines}, 10'b11_1010_0110);
      give_verdict();
   end
endmodule
`default_nettype wire
